// >>> include/fieldbus_supervision_pkg.sv
// constants for the fieldbus channel supervision block
`default_nettype none
package fieldbus_supervision_pkg;
   localparam int NUM_CH = 4;
   localparam int NUM_PID = 13;
   // relevant parameter identifiers
   localparam logic [3:0] PID_CMD = 4'h0;
   localparam logic [3:0] PID_CMDSW = 4'h1;
   localparam logic [3:0] PID_REFSW1B = 4'h2;
   localparam logic [3:0] PID_REFSW12 = 4'h3;
   localparam logic [3:0] PID_REF = 4'h4;
   localparam logic [3:0] PID_SUM2 = 4'h5;
   localparam logic [3:0] PID_SUM3 = 4'h6;
   localparam logic [3:0] PID_SUB2 = 4'h7;
   localparam logic [3:0] PID_SUB3 = 4'h8;
   localparam logic [3:0] PID_PIDREF = 4'h9;
   localparam logic [3:0] PID_PIDFB = 4'hA;
   localparam logic [3:0] PID_MUL2 = 4'hB;
   localparam logic [3:0] PID_MUL3 = 4'hC;
   // register byte offsets
   localparam logic [7:0] OFS_CTRL = 8'h00;
   localparam logic [7:0] OFS_CW_TIMEOUT = 8'h04;
   localparam logic [7:0] OFS_FLOC_TIMEOUT = 8'h08;
   localparam logic [7:0] OFS_REQ_MASK = 8'h0C;
   localparam logic [7:0] OFS_STATUS = 8'h10;
   localparam logic [7:0] OFS_STATE_WORD = 8'h14;
   localparam logic [7:0] OFS_REF = 8'h18;
   localparam logic [7:0] OFS_CMD = 8'h1C;
   // control register fields
   localparam int CTRL_RESP_LSB = 0;
   localparam int CTRL_CMDCH_LSB = 4;
   localparam int CTRL_REFCH_LSB = 6;
   localparam int CTRL_FAULT_RST = 8;
   localparam int CTRL_INT_CLR = 9;
   // reset values
   localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
   localparam logic [15:0] CW_TIMEOUT_RESET = 16'h0000;
   localparam logic [15:0] FLOC_TIMEOUT_RESET = 16'h000A;
   localparam logic [12:0] REQ_MASK_RESET = 13'h0011;
   // command word fields carried to the drive
   localparam int CMD_RUN_BIT = 0;
   localparam int CMD_DIR_BIT = 1;
   // operating state word bit positions
   localparam int SW_READY = 0;
   localparam int SW_ON = 1;
   localparam int SW_OPEN = 2;
   localparam int SW_FAULT = 3;
   localparam int SW_POWER = 4;
   localparam int SW_NQSTOP = 5;
   localparam int SW_SODIS = 6;
   localparam int SW_WARN = 7;
   localparam int SW_NLOCAL = 9;
   localparam int SW_REFOK = 10;
   localparam int SW_LIMIT = 11;
   localparam int SW_STOPKEY = 14;
   localparam int SW_REV = 15;
   // timing
   localparam int CLK_PERIOD_NS = 10;
   localparam int MS_NS = 1000000;
   localparam int BLINK_MS = 500;
   typedef enum logic [1:0]
   {
      RESP_FAULT = 2'b00,
      RESP_MAINT = 2'b01,
      RESP_FALLBACK = 2'b10,
      RESP_IGNORE = 2'b11
   } resp_t;
   typedef enum logic [2:0]
   {
      ST_REMOTE = 3'b001,
      ST_LOCAL = 3'b010,
      ST_DELAY = 3'b100
   } floc_t;
endpackage
`default_nettype wire

// >>> hw/fieldbus_channel_supervision.sv
// fieldbus channel supervision with apb registers
//
// Our own choices: the APB interface to the registers and the register addresses.
`timescale 1ns/10ps
`default_nettype none
// Summary of operation
// - ethernet watches replacement, duplicate ip, overload, timeout
// - thirteen parameter kinds make a channel relevant
// - first relevant write arms channel supervision
// - warning on armed channel raises interruption
// - interruption applies configured response
// - unarmed channel warning is ignored
// - channel enabled once all required parameters written
// - start only with command and reference enabled
// - state 4 to 5 needs reference and command
// - warning or forced local disables channel
// - leaving local loads local run, direction, reference
// - supervision resumes after forced local delay
// - remote control waits for new reference, command
// - references reported in tenths of hertz
// - state word bits 0 to 4
// - state word bits 5 to 9
// - state word bits 10 to 13
// - state word bits 14 and 15
// - fault held until cause gone and reset
// - red network blink after connection loss
module fieldbus_channel_supervision
   import fieldbus_supervision_pkg::*;
#(
   parameter int TICK_CYCLES = MS_NS / CLK_PERIOD_NS
)
(
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic paramWrStb,
   input wire logic [1:0] paramWrCh,
   input wire logic [3:0] paramWrId,
   input wire logic [15:0] paramWrData,
   input wire logic [NUM_CH-1:0] chWarnPin,
   input wire logic fdrErrPin,
   input wire logic dupIpPin,
   input wire logic overloadPin,
   input wire logic connClosedPin,
   input wire logic forcedLocal,
   input wire logic localRun,
   input wire logic localDir,
   input wire logic [15:0] localRef,
   input wire logic readyToSwitchOn,
   input wire logic switchedOn,
   input wire logic operationEnabled,
   input wire logic driveFault,
   input wire logic powerStageOn,
   input wire logic quickStop,
   input wire logic switchOnDisabled,
   input wire logic driveWarning,
   input wire logic refReached,
   input wire logic refOutOfLimits,
   input wire logic stopKey,
   input wire logic reverseRotation,
   output logic commInterrupt,
   output logic faultState,
   output logic maintRun,
   output logic fallbackActive,
   output logic startAllowed,
   output logic opEnableAllowed,
   output logic activeRun,
   output logic activeDir,
   output logic [15:0] activeRef,
   output logic nsRedOn,
   output logic [15:0] operating_state_word
);
   localparam int SYNC_W = NUM_CH + 4;
   localparam logic [12:0] ALL_PID = 13'h1FFF;

   function automatic logic chSel(input logic [NUM_CH-1:0] v, input logic [1:0] ch);
      chSel = v[ch];
   endfunction

   logic [SYNC_W-1:0] meta_q, sync_q;
   logic [31:0] tickCnt_q, tickCnt_d;
   logic [31:0] ctrl_q, ctrl_d;
   logic [15:0] cwTimeout_q, cwTimeout_d, flocTimeout_q, flocTimeout_d;
   logic [12:0] reqMask_q, reqMask_d;
   logic [12:0] written_q [NUM_CH];
   logic [12:0] written_d [NUM_CH];
   logic [NUM_CH-1:0] armed_q, armed_d;
   logic [15:0] toCnt_q, toCnt_d, flocCnt_q, flocCnt_d, blinkCnt_q, blinkCnt_d;
   floc_t floc_q, floc_d;
   logic gotCmd_q, gotCmd_d, gotRef_q, gotRef_d, blocked_q, blocked_d;
   logic [15:0] cmdUsed_q, cmdUsed_d, refUsed_q, refUsed_d, ethRef_q, ethRef_d;
   logic intFlag_q, intFlag_d, fault_q, fault_d, maint_q, maint_d, fb_q, fb_d;
   logic connUp_q, connUp_d, nsLost_q, nsLost_d, blink_q, blink_d;
   logic [31:0] prdata_q, prdata_d;
   logic [15:0] stateWord_q, stateWord_d;
   logic [31:0] rdMux;
   logic tick, cwValid, expired, supervising, intEvent, access, wrEn, mapped;
   logic [NUM_CH-1:0] warn, enabled, armedWarn;
   logic [1:0] cmdCh, refCh;
   logic cmdWr, refWr;

   assign cmdCh = ctrl_q[CTRL_CMDCH_LSB +: 2];
   assign refCh = ctrl_q[CTRL_REFCH_LSB +: 2];
   assign access = psel & penable;
   assign wrEn = access & pwrite;
   assign pready = 1'b1;
   assign pslverr = access & ~mapped;
   assign tick = (tickCnt_q == TICK_CYCLES - 1);
   assign cwValid = paramWrStb && paramWrCh == 2'd0 && paramWrId == PID_CMD;
   assign cmdWr = paramWrStb && paramWrCh == cmdCh && paramWrId == PID_CMD;
   assign refWr = paramWrStb && paramWrCh == refCh && paramWrId == PID_REF;
   assign expired = armed_q[0] && cwTimeout_q != 16'h0000 && toCnt_q >= cwTimeout_q;

   always_comb
   begin
      warn = sync_q[NUM_CH-1:0];
      // ethernet channel conditions
      warn[0] = sync_q[0] | sync_q[NUM_CH] | sync_q[NUM_CH+1] | sync_q[NUM_CH+2] | expired;
      armedWarn = warn & armed_q;
      for (int i = 0; i < NUM_CH; i++)
      begin
         enabled[i] = ((written_q[i] & reqMask_q) == reqMask_q) && !forcedLocal;
      end
   end

   assign supervising = (floc_q == ST_REMOTE);
   assign intEvent = supervising && (armedWarn != '0);

   always_comb
   begin
      mapped = 1'b1;
      rdMux = 32'h0000_0000;
      unique case (paddr)
         OFS_CTRL: rdMux = {ctrl_q[31:10], 2'b00, ctrl_q[7:0]};
         OFS_CW_TIMEOUT: rdMux = {16'h0000, cwTimeout_q};
         OFS_FLOC_TIMEOUT: rdMux = {16'h0000, flocTimeout_q};
         OFS_REQ_MASK: rdMux = {19'h0_0000, reqMask_q};
         OFS_STATUS: rdMux = {16'h0000, floc_q, blocked_q, fb_q, maint_q, fault_q,
            intFlag_q, enabled, armed_q};
         OFS_STATE_WORD: rdMux = {16'h0000, stateWord_q};
         OFS_REF: rdMux = {ethRef_q, refUsed_q};
         OFS_CMD: rdMux = {16'h0000, cmdUsed_q};
         default: mapped = 1'b0;
      endcase
   end

   always_comb
   begin
      tickCnt_d = tick ? 32'h0000_0000 : tickCnt_q + 32'h0000_0001;
      ctrl_d = ctrl_q;
      cwTimeout_d = cwTimeout_q;
      flocTimeout_d = flocTimeout_q;
      reqMask_d = reqMask_q;
      prdata_d = (psel && !penable) ? rdMux : prdata_q;
      if (wrEn)
      begin
         unique case (paddr)
            OFS_CTRL: ctrl_d = pwdata;
            OFS_CW_TIMEOUT: cwTimeout_d = pwdata[15:0];
            OFS_FLOC_TIMEOUT: flocTimeout_d = pwdata[15:0];
            OFS_REQ_MASK: reqMask_d = pwdata[12:0] & ALL_PID;
            default: ;
         endcase
      end
   end

   // channel arming and enabling
   always_comb
   begin
      armed_d = armed_q;
      for (int i = 0; i < NUM_CH; i++)
      begin
         written_d[i] = written_q[i];
         if (warn[i] || forcedLocal)
         begin
            written_d[i] = 13'h0000;
         end
      end
      if (paramWrStb && paramWrId < NUM_PID)
      begin
         armed_d[paramWrCh] = 1'b1;
         written_d[paramWrCh][paramWrId] = 1'b1;
      end
      toCnt_d = toCnt_q;
      if (cwValid)
      begin
         toCnt_d = 16'h0000;
      end
      else if (tick && !expired && armed_q[0] && cwTimeout_q != 16'h0000)
      begin
         toCnt_d = toCnt_q + 16'h0001;
      end
   end

   // forced local handling
   always_comb
   begin
      floc_d = floc_q;
      flocCnt_d = flocCnt_q;
      gotCmd_d = gotCmd_q | cmdWr;
      gotRef_d = gotRef_q | refWr;
      blocked_d = blocked_q;
      cmdUsed_d = cmdUsed_q;
      refUsed_d = refUsed_q;
      unique case (floc_q)
         ST_REMOTE:
         begin
            if (forcedLocal)
            begin
               floc_d = ST_LOCAL;
            end
         end
         ST_LOCAL:
         begin
            if (!forcedLocal)
            begin
               floc_d = ST_DELAY;
               flocCnt_d = 16'h0000;
               cmdUsed_d = 16'h0000;
               cmdUsed_d[CMD_RUN_BIT] = localRun;
               cmdUsed_d[CMD_DIR_BIT] = localDir;
               refUsed_d = localRef;
               blocked_d = 1'b1;
               gotCmd_d = 1'b0;
               gotRef_d = 1'b0;
            end
         end
         ST_DELAY:
         begin
            if (forcedLocal)
            begin
               floc_d = ST_LOCAL;
            end
            else if (flocCnt_q >= flocTimeout_q)
            begin
               floc_d = ST_REMOTE;
            end
            else if (tick)
            begin
               flocCnt_d = flocCnt_q + 16'h0001;
            end
         end
         default: floc_d = ST_REMOTE;
      endcase
      if (blocked_q && floc_q != ST_LOCAL && gotCmd_d && gotRef_d)
      begin
         blocked_d = 1'b0;
      end
      if (!forcedLocal && !blocked_d && floc_q != ST_LOCAL)
      begin
         if (cmdWr)
         begin
            cmdUsed_d = paramWrData;
         end
         if (refWr)
         begin
            refUsed_d = paramWrData;
         end
      end
   end

   // interruption response and network led
   always_comb
   begin
      ethRef_d = (paramWrStb && paramWrCh == 2'd0 && paramWrId == PID_REF) ?
         paramWrData : ethRef_q;
      intFlag_d = intFlag_q;
      maint_d = maint_q;
      fb_d = fb_q;
      fault_d = fault_q;
      if (wrEn && paddr == OFS_CTRL && pwdata[CTRL_INT_CLR])
      begin
         intFlag_d = 1'b0;
         maint_d = 1'b0;
         fb_d = 1'b0;
      end
      if (wrEn && paddr == OFS_CTRL && pwdata[CTRL_FAULT_RST] && armedWarn == '0)
      begin
         fault_d = 1'b0;
      end
      if (intEvent)
      begin
         intFlag_d = 1'b1;
         unique case (resp_t'(ctrl_q[CTRL_RESP_LSB +: 2]))
            RESP_FAULT: fault_d = 1'b1;
            RESP_MAINT: maint_d = 1'b1;
            RESP_FALLBACK: fb_d = 1'b1;
            RESP_IGNORE: ;
         endcase
      end
      connUp_d = connUp_q | cwValid;
      nsLost_d = nsLost_q;
      if (cwValid)
      begin
         nsLost_d = 1'b0;
      end
      else if (connUp_q && (sync_q[NUM_CH+3] || expired))
      begin
         nsLost_d = 1'b1;
      end
      blinkCnt_d = blinkCnt_q;
      blink_d = blink_q;
      if (tick)
      begin
         if (blinkCnt_q == 16'(BLINK_MS - 1))
         begin
            blinkCnt_d = 16'h0000;
            blink_d = ~blink_q;
         end
         else
         begin
            blinkCnt_d = blinkCnt_q + 16'h0001;
         end
      end
   end

   // operating state word
   always_comb
   begin
      stateWord_d = 16'h0000;
      stateWord_d[SW_READY] = readyToSwitchOn;
      stateWord_d[SW_ON] = switchedOn;
      stateWord_d[SW_OPEN] = operationEnabled;
      stateWord_d[SW_FAULT] = driveFault | fault_q;
      stateWord_d[SW_POWER] = powerStageOn;
      stateWord_d[SW_NQSTOP] = ~quickStop;
      stateWord_d[SW_SODIS] = switchOnDisabled;
      stateWord_d[SW_WARN] = driveWarning | intFlag_q;
      stateWord_d[SW_NLOCAL] = ~forcedLocal;
      stateWord_d[SW_REFOK] = refReached;
      stateWord_d[SW_LIMIT] = refOutOfLimits;
      stateWord_d[SW_STOPKEY] = stopKey;
      stateWord_d[SW_REV] = reverseRotation;
   end

   always_ff @(posedge clk)
   begin
      meta_q <= {connClosedPin, overloadPin, dupIpPin, fdrErrPin, chWarnPin};
      sync_q <= meta_q;
      if (sys_rst)
      begin
         meta_q <= '0;
         sync_q <= '0;
         tickCnt_q <= 32'h0000_0000;
         ctrl_q <= CTRL_RESET;
         cwTimeout_q <= CW_TIMEOUT_RESET;
         flocTimeout_q <= FLOC_TIMEOUT_RESET;
         reqMask_q <= REQ_MASK_RESET;
         for (int i = 0; i < NUM_CH; i++)
         begin
            written_q[i] <= 13'h0000;
         end
         armed_q <= '0;
         toCnt_q <= 16'h0000;
         floc_q <= ST_REMOTE;
         flocCnt_q <= 16'h0000;
         gotCmd_q <= 1'b0;
         gotRef_q <= 1'b0;
         blocked_q <= 1'b0;
         cmdUsed_q <= 16'h0000;
         refUsed_q <= 16'h0000;
         ethRef_q <= 16'h0000;
         intFlag_q <= 1'b0;
         fault_q <= 1'b0;
         maint_q <= 1'b0;
         fb_q <= 1'b0;
         connUp_q <= 1'b0;
         nsLost_q <= 1'b0;
         blinkCnt_q <= 16'h0000;
         blink_q <= 1'b0;
         prdata_q <= 32'h0000_0000;
         stateWord_q <= 16'h0000;
      end
      else
      begin
         tickCnt_q <= tickCnt_d;
         ctrl_q <= ctrl_d;
         cwTimeout_q <= cwTimeout_d;
         flocTimeout_q <= flocTimeout_d;
         reqMask_q <= reqMask_d;
         written_q <= written_d;
         armed_q <= armed_d;
         toCnt_q <= toCnt_d;
         floc_q <= floc_d;
         flocCnt_q <= flocCnt_d;
         gotCmd_q <= gotCmd_d;
         gotRef_q <= gotRef_d;
         blocked_q <= blocked_d;
         cmdUsed_q <= cmdUsed_d;
         refUsed_q <= refUsed_d;
         ethRef_q <= ethRef_d;
         intFlag_q <= intFlag_d;
         fault_q <= fault_d;
         maint_q <= maint_d;
         fb_q <= fb_d;
         connUp_q <= connUp_d;
         nsLost_q <= nsLost_d;
         blinkCnt_q <= blinkCnt_d;
         blink_q <= blink_d;
         prdata_q <= prdata_d;
         stateWord_q <= stateWord_d;
      end
   end

   assign prdata = prdata_q;
   assign commInterrupt = intEvent;
   assign faultState = fault_q;
   assign maintRun = maint_q;
   assign fallbackActive = fb_q;
   assign startAllowed = chSel(enabled, cmdCh) && chSel(enabled, refCh) && !blocked_q
      && !fault_q;
   assign opEnableAllowed = startAllowed && written_q[cmdCh][PID_CMD]
      && written_q[refCh][PID_REF];
   assign activeRun = cmdUsed_q[CMD_RUN_BIT];
   assign activeDir = cmdUsed_q[CMD_DIR_BIT];
   assign activeRef = refUsed_q;
   assign nsRedOn = nsLost_q & blink_q;
   assign operating_state_word = stateWord_q;
endmodule
`default_nettype wire

// >>> bench/fieldbus_channel_supervision_props.sv
// port checks for the fieldbus channel supervision block
`timescale 1ns/10ps
`default_nettype none
module fieldbus_channel_supervision_props
   import fieldbus_supervision_pkg::*;
(
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic forcedLocal,
   input wire logic localRun,
   input wire logic localDir,
   input wire logic [15:0] localRef,
   input wire logic readyToSwitchOn,
   input wire logic switchedOn,
   input wire logic operationEnabled,
   input wire logic driveFault,
   input wire logic powerStageOn,
   input wire logic quickStop,
   input wire logic switchOnDisabled,
   input wire logic driveWarning,
   input wire logic commInterrupt,
   input wire logic faultState,
   input wire logic maintRun,
   input wire logic fallbackActive,
   input wire logic startAllowed,
   input wire logic activeRun,
   input wire logic activeDir,
   input wire logic [15:0] activeRef,
   input wire logic [15:0] operating_state_word
);
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (sys_rst);
   logic resetWr;
   assign resetWr = psel && penable && pwrite && paddr == OFS_CTRL && pwdata[CTRL_FAULT_RST];
   apb_ready_a: assert property (pready) else $error("pready low");
   slverr_phase_a: assert property (pslverr |-> psel && penable)
      else $error("pslverr outside access");
   resp_cause_a: assert property (
      $rose(faultState) || $rose(maintRun) || $rose(fallbackActive) |-> $past(commInterrupt))
      else $error("response without interruption");
   fault_hold_a: assert property ($fell(faultState) |-> $past(resetWr))
      else $error("fault left without reset write");
   word_low_a: assert property (
      !$past(sys_rst) |-> operating_state_word[SW_READY] == $past(readyToSwitchOn)
      && operating_state_word[SW_ON] == $past(switchedOn)
      && operating_state_word[SW_OPEN] == $past(operationEnabled)
      && operating_state_word[SW_POWER] == $past(powerStageOn)
      && operating_state_word[SW_FAULT] == ($past(driveFault) || $past(faultState)))
      else $error("state word low bits wrong");
   word_mid_a: assert property (
      !$past(sys_rst) |-> operating_state_word[SW_NQSTOP] == !$past(quickStop)
      && operating_state_word[SW_SODIS] == $past(switchOnDisabled)
      && operating_state_word[SW_NLOCAL] == !$past(forcedLocal)
      && (operating_state_word[SW_WARN] || !$past(driveWarning)))
      else $error("state word middle bits wrong");
   local_block_a: assert property (forcedLocal [*2] |-> !startAllowed)
      else $error("start allowed in forced local");
   local_load_a: assert property (
      $fell(forcedLocal) |-> ##[0:2] (activeRun == localRun && activeDir == localDir
      && activeRef == localRef))
      else $error("local values not loaded on exit");
endmodule
bind fieldbus_channel_supervision fieldbus_channel_supervision_props i_props (.clk, .sys_rst,
   .psel, .penable, .pwrite, .paddr, .pwdata, .pready, .pslverr, .forcedLocal, .localRun,
   .localDir, .localRef, .readyToSwitchOn, .switchedOn, .operationEnabled, .driveFault,
   .powerStageOn, .quickStop, .switchOnDisabled, .driveWarning, .commInterrupt, .faultState,
   .maintRun, .fallbackActive, .startAllowed, .activeRun, .activeDir, .activeRef,
   .operating_state_word);
`default_nettype wire

// >>> bench/network_controller_model.sv
// network controller model writing parameters over the fieldbus
`timescale 1ns/10ps
`default_nettype none
module network_controller_model
(
   input wire logic clk,
   output logic paramWrStb,
   output logic [1:0] paramWrCh,
   output logic [3:0] paramWrId,
   output logic [15:0] paramWrData
);
   initial
   begin
      paramWrStb = 1'h0;
      paramWrCh = 2'h0;
      paramWrId = 4'hF;
      paramWrData = 16'h0000;
   end
   // one-cycle write, qualifiers turned over once released
   task automatic send(input logic [1:0] ch, input logic [3:0] id, input logic [15:0] data);
      @(posedge clk);
      paramWrStb <= 1'h1;
      paramWrCh <= ch;
      paramWrId <= id;
      paramWrData <= data;
      @(posedge clk);
      paramWrStb <= 1'h0;
      paramWrCh <= ~ch;
      paramWrId <= ~id;
      paramWrData <= ~data;
   endtask
endmodule
`default_nettype wire

// >>> bench/fieldbus_channel_supervision_tb.sv
// self-checking bench for the fieldbus channel supervision block
`timescale 1ns/10ps
`default_nettype none
module fieldbus_channel_supervision_tb;
   import fieldbus_supervision_pkg::*;
   localparam int TICK = 10;
   logic clk = 1'h0;
   logic sys_rst = 1'h1;
   logic psel = 1'h0, penable = 1'h0, pwrite = 1'h0, pready, pslverr, se;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0000_0000, prdata, rd;
   logic paramWrStb;
   logic [1:0] paramWrCh;
   logic [3:0] paramWrId;
   logic [15:0] paramWrData;
   logic [3:0] chWarnPin = 4'h0;
   logic forcedLocal = 1'h0, localRun = 1'h0, localDir = 1'h0;
   logic [15:0] localRef = 16'h0000, activeRef, operating_state_word;
   logic [11:0] drv = 12'h000;
   logic [2:0] eth = 3'h0;
   logic commInterrupt, faultState, maintRun, fallbackActive, startAllowed, opEnableAllowed;
   logic activeRun, activeDir, nsRedOn;
   int err_total = 0;
   int n_tests = 0;
   always #5 clk = ~clk;
   fieldbus_channel_supervision #(.TICK_CYCLES(TICK)) i_dut (.clk, .sys_rst, .psel, .penable,
      .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .paramWrStb, .paramWrCh, .paramWrId,
      .paramWrData, .chWarnPin, .fdrErrPin(eth[0]), .dupIpPin(eth[1]), .overloadPin(eth[2]),
      .connClosedPin(1'h0), .forcedLocal, .localRun, .localDir, .localRef,
      .readyToSwitchOn(drv[0]), .switchedOn(drv[1]), .operationEnabled(drv[2]),
      .driveFault(drv[3]), .powerStageOn(drv[4]), .quickStop(drv[5]),
      .switchOnDisabled(drv[6]), .driveWarning(drv[7]), .refReached(drv[8]),
      .refOutOfLimits(drv[9]), .stopKey(drv[10]), .reverseRotation(drv[11]), .commInterrupt,
      .faultState, .maintRun, .fallbackActive, .startAllowed, .opEnableAllowed, .activeRun,
      .activeDir, .activeRef, .nsRedOn, .operating_state_word);
   network_controller_model i_plc (.clk, .paramWrStb, .paramWrCh, .paramWrId, .paramWrData);
   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      n_tests++;
      if (got !== exp)
      begin
         err_total++;
         $display("mismatch %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic ticks(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      psel <= 1'h1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'h1;
      @(posedge clk);
      while (pready !== 1'h1)
         @(posedge clk);
      rd = prdata;
      se = pslverr;
      psel <= 1'h0;
      penable <= 1'h0;
   endtask
   function automatic logic [15:0] exp_word(input logic [11:0] d);
      return {d[11:10], 2'h0, d[9:8], 1'h1, 1'h0, d[7:6], ~d[5], d[4:0]};
   endfunction
   task automatic t_regs();
      apb(1'h0, OFS_CTRL, 0);
      chk("ctrl", 32'h0000_0000, rd);
      apb(1'h0, OFS_FLOC_TIMEOUT, 0);
      chk("floc delay", 32'h0000_000A, rd);
      apb(1'h0, OFS_REQ_MASK, 0);
      chk("mask", 32'h0000_0011, rd);
      apb(1'h0, OFS_STATUS, 0);
      chk("status", 32'h0000_2000, rd);
      apb(1'h0, 8'h40, 0);
      chk("unmapped", 32'h0000_0001, {rd[30:0], se});
      $display("end t_regs");
   endtask
   task automatic t_word();
      for (int i = 0; i < 12; i++)
      begin
         @(posedge clk);
         drv <= 12'h001 << i;
         ticks(2);
         chk("word", exp_word(drv) & 16'hCEFF, operating_state_word & 16'hCEFF);
      end
      @(posedge clk);
      drv <= 12'hD53;
      apb(1'h0, OFS_STATE_WORD, 0);
      chk("word rd", exp_word(12'hD53) & 16'hCEFF, rd & 32'h0000_CEFF);
      @(posedge clk);
      drv <= 12'h000;
      $display("end t_word");
   endtask
   task automatic t_arm();
      @(posedge clk);
      chWarnPin <= 4'h2;
      ticks(8);
      apb(1'h0, OFS_STATUS, 0);
      chk("unarmed warn", 32'h0000_2000, rd);
      @(posedge clk);
      chWarnPin <= 4'h0;
      i_plc.send(2'h0, PID_CMD, 16'h0001);
      apb(1'h0, OFS_STATUS, 0);
      chk("armed", 32'h0000_2001, rd);
      chk("start cmd only", 2'h0, {startAllowed, opEnableAllowed});
      i_plc.send(2'h0, PID_REF, 16'h01F4);
      apb(1'h0, OFS_STATUS, 0);
      chk("enabled", 32'h0000_2011, rd);
      chk("start both", 2'h3, {startAllowed, opEnableAllowed});
      apb(1'h0, OFS_REF, 0);
      chk("ref", 32'h01F4_01F4, rd);
      @(posedge clk);
      chWarnPin <= 4'h1;
      for (int k = 0; k < 10 && faultState !== 1'h1; k++)
         @(posedge clk);
      apb(1'h1, OFS_CTRL, 32'h0000_0100);
      apb(1'h0, OFS_STATUS, 0);
      chk("fault", 32'h0000_2301, rd);
      chk("start warn", 2'h1, {startAllowed, commInterrupt});
      @(posedge clk);
      chWarnPin <= 4'h0;
      ticks(4);
      apb(1'h1, OFS_CTRL, 32'h0000_0300);
      apb(1'h0, OFS_STATUS, 0);
      chk("fault reset", 32'h0000_2001, rd);
      $display("end t_arm");
   endtask
   task automatic t_modes();
      for (int r = 1; r < 4; r++)
      begin
         apb(1'h1, OFS_CTRL, r);
         @(posedge clk);
         eth <= 3'h1 << (r - 1);
         ticks(6);
         chk("response", 3'h4 >> r, {faultState, maintRun, fallbackActive});
         @(posedge clk);
         eth <= 3'h0;
         ticks(4);
         apb(1'h1, OFS_CTRL, r | 32'h0000_0200);
         ticks(1);
         chk("response clr", 3'h0, {faultState, maintRun, fallbackActive});
      end
      $display("end t_modes");
   endtask
   task automatic t_mask();
      apb(1'h1, OFS_REQ_MASK, 32'h0000_1FFF);
      for (int i = 0; i < 12; i++)
         i_plc.send(2'h1, i, 16'h0000);
      apb(1'h0, OFS_STATUS, 0);
      chk("partial", 32'h0000_2003, rd);
      i_plc.send(2'h1, PID_MUL3, 16'h0000);
      i_plc.send(2'h2, 4'hD, 16'h0000);
      apb(1'h0, OFS_STATUS, 0);
      chk("all ids", 32'h0000_2023, rd);
      apb(1'h1, OFS_REQ_MASK, 32'h0000_0011);
      $display("end t_mask");
   endtask
   task automatic t_local();
      i_plc.send(2'h0, PID_CMD, 16'h0001);
      i_plc.send(2'h0, PID_REF, 16'h0100);
      apb(1'h1, OFS_FLOC_TIMEOUT, 5);
      @(posedge clk);
      localRun <= 1'h1;
      localDir <= 1'h1;
      localRef <= 16'h1234;
      forcedLocal <= 1'h1;
      ticks(3);
      chk("local start", 2'h0, {startAllowed, operating_state_word[SW_NLOCAL]});
      @(posedge clk);
      forcedLocal <= 1'h0;
      ticks(3);
      chk("loaded", {2'h3, 16'h1234}, {activeRun, activeDir, activeRef});
      apb(1'h0, OFS_STATUS, 0);
      chk("delay", 4'h9, rd[15:12]);
      ticks(10);
      apb(1'h0, OFS_STATUS, 0);
      chk("still delay", 3'h4, rd[15:13]);
      ticks(50);
      apb(1'h0, OFS_STATUS, 0);
      chk("remote", 3'h1, rd[15:13]);
      i_plc.send(2'h0, PID_CMD, 16'h0000);
      apb(1'h0, OFS_STATUS, 0);
      chk("blocked", {1'h1, 16'h1234}, {rd[12], activeRef});
      i_plc.send(2'h0, PID_REF, 16'h0200);
      apb(1'h0, OFS_STATUS, 0);
      chk("unblocked", 1'h0, rd[12]);
      $display("end t_local");
   endtask
   task automatic t_timeout();
      apb(1'h1, OFS_CTRL, 32'h0000_0203);
      apb(1'h1, OFS_CW_TIMEOUT, 2);
      i_plc.send(2'h0, PID_CMD, 16'h0001);
      ticks(4);
      i_plc.send(2'h0, PID_CMD, 16'h0001);
      apb(1'h0, OFS_STATUS, 0);
      chk("no expiry", 1'h0, rd[8]);
      ticks(40);
      apb(1'h0, OFS_STATUS, 0);
      chk("expiry", 1'h1, rd[8]);
      for (int k = 0; k < 12000 && nsRedOn !== 1'h1; k++)
         @(posedge clk);
      chk("red blink", 1'h1, nsRedOn);
      $display("end t_timeout");
   endtask
   task automatic tally_and_finish();
      $display("checks %0d mismatches %0d", n_tests, err_total);
      if (err_total == 0 && n_tests > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask
   initial
   begin
      repeat (40000) @(posedge clk);
      err_total++;
      tally_and_finish();
   end
   initial
   begin
      repeat (10) @(posedge clk);
      sys_rst <= 1'h0;
      t_regs();
      t_word();
      t_arm();
      t_modes();
      t_mask();
      t_local();
      t_timeout();
      tally_and_finish();
   end
endmodule
`default_nettype wire
